// ===== logic/sser_host.sv
// Purpose: host end: frames link commands ordered over AXI4-Lite
// Assumes: DIV of at least 3 MCLK cycles per sck half period
// Notes: up to four data bytes per frame, first write byte in top bits, read bytes right-aligned
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
module sser_host #(
  parameter int DIV = 4
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  sser_link_if.host LINK
);
  if (DIV < 3 || DIV > 255) begin : g_chk
    $error("DIV must lie in 3..255");
  end
  localparam logic [7:0] DIV_M1 = 8'(DIV - 1);

  typedef enum logic [2:0] {
    HS_IDLE, HS_OP, HS_ADDR, HS_DUMMY, HS_DATA, HS_END
  } sser_hst_t;

  typedef struct packed {
    sser_hst_t st;
    logic [7:0] dcnt;
    logic ph;
    logic cs_n;
    logic sck;
    logic [3:0] hout;
    logic [3:0] hoe;
    logic [31:0] cmdw;
    logic [31:0] areg;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [63:0] tx;
    logic [5:0] bits;
    logic [3:0] dum;
    logic done;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sser_host_t;

  localparam sser_host_t HOST_RST = '{st: HS_IDLE, cs_n: 1'b1,
    default: '0};

  sser_host_t r;
  sser_host_t s;
  logic tick;
  logic last;
  logic is_wr;
  logic [3:0] w;
  logic [2:0] nbc;
  logic [31:0] c;
  sser_hst_t post;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        merge[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
  endfunction

  always_comb begin
    s = r;
    last = 1'b0;
    tick = (r.dcnt == DIV_M1);
    w = sser_pkg::lane_bits(r.cmdw[sser_pkg::CMD_LANE_LSB +: 2]);
    is_wr = (r.cmdw[7:0] == sser_pkg::OP_SEC_WR);
    nbc = r.cmdw[sser_pkg::CMD_NB_LSB +: 3];
    if (nbc > sser_pkg::NB_MAX) begin
      nbc = sser_pkg::NB_MAX;
    end
    post = (nbc == '0) ? HS_END : HS_DATA;
    c = merge(r.cmdw, r.wd, r.ws);
    // Write channel: address and data taken in either order
    if (BREADY && r.bvalid) begin
      s.bvalid = 1'b0;
    end
    if (AWVALID && r.awready) begin
      s.aw_got = 1'b1;
      s.aw_addr = AWADDR;
    end
    if (WVALID && r.wready) begin
      s.w_got = 1'b1;
      s.wd = WDATA;
      s.ws = WSTRB;
    end
    if (r.aw_got && r.w_got && !r.bvalid) begin
      s.aw_got = 1'b0;
      s.w_got = 1'b0;
      s.bvalid = 1'b1;
      s.bresp = sser_pkg::AXI_OKAY;
      case (r.aw_addr)
        sser_pkg::HR_CMD: begin
          // A command written while busy is dropped
          if (r.st == HS_IDLE) begin
            s.cmdw = c;
            s.tx = {c[7:0], r.areg[23:0], r.wdat};
            s.st = HS_OP;
            s.bits = sser_pkg::OP_BITS;
            s.cs_n = 1'b0;
            s.ph = 1'b0;
            s.dcnt = '0;
            s.done = 1'b0;
            s.rdat = '0;
          end
        end
        sser_pkg::HR_ADDR: s.areg = merge(r.areg, r.wd, r.ws) & 32'h00FFFFFF;
        sser_pkg::HR_WDATA: s.wdat = merge(r.wdat, r.wd, r.ws);
        sser_pkg::HR_RDATA, sser_pkg::HR_STAT: s.bresp = sser_pkg::AXI_OKAY;
        default: s.bresp = sser_pkg::AXI_SLVERR;
      endcase
    end
    s.awready = !s.aw_got && !s.bvalid;
    s.wready = !s.w_got && !s.bvalid;
    // Read channel
    if (RREADY && r.rvalid) begin
      s.rvalid = 1'b0;
    end
    if (ARVALID && r.arready) begin
      s.rvalid = 1'b1;
      s.rresp = sser_pkg::AXI_OKAY;
      case (ARADDR)
        sser_pkg::HR_CMD: s.rdata = r.cmdw;
        sser_pkg::HR_ADDR: s.rdata = r.areg;
        sser_pkg::HR_WDATA: s.rdata = r.wdat;
        sser_pkg::HR_RDATA: s.rdata = r.rdat;
        sser_pkg::HR_STAT: begin
          s.rdata = '0;
          s.rdata[sser_pkg::STAT_BUSY_BIT] = (r.st != HS_IDLE);
          s.rdata[sser_pkg::STAT_DONE_BIT] = r.done;
        end
        default: begin
          s.rdata = '0;
          s.rresp = sser_pkg::AXI_SLVERR;
        end
      endcase
    end
    s.arready = !s.rvalid;
    // Frame sequencer: half period per tick, drive low then sample high
    if (r.st != HS_IDLE) begin
      s.dcnt = tick ? '0 : r.dcnt + 8'h01;
      if (tick && !r.ph) begin
        s.sck = 1'b0;
        s.ph = 1'b1;
        s.hoe = '0;
        if (r.st == HS_END) begin
          // CS rises right after the last bit
          s.cs_n = 1'b1;
          s.st = HS_IDLE;
          s.done = 1'b1;
          s.ph = 1'b0;
        end else if (r.st != HS_DUMMY && (r.st != HS_DATA || is_wr)) begin
          // Lanes per mode, MSB first
          case (r.cmdw[sser_pkg::CMD_LANE_LSB +: 2])
            sser_pkg::LANES_DUAL: begin
              s.hout = {2'b00, r.tx[63:62]};
              s.hoe = sser_pkg::OE_DUAL;
            end
            sser_pkg::LANES_QUAD: begin
              s.hout = r.tx[63:60];
              s.hoe = sser_pkg::OE_QUAD;
            end
            default: begin
              s.hout = {3'b000, r.tx[63]};
              s.hoe = sser_pkg::OE_HOST_SINGLE;
            end
          endcase
          s.tx = r.tx << w;
        end
      end else if (tick) begin
        s.sck = 1'b1;
        s.ph = 1'b0;
        if (r.st == HS_DATA && !is_wr) begin
          case (r.cmdw[sser_pkg::CMD_LANE_LSB +: 2])
            sser_pkg::LANES_DUAL: s.rdat = {r.rdat[29:0], LINK.d_out[1:0]};
            sser_pkg::LANES_QUAD: s.rdat = {r.rdat[27:0], LINK.d_out};
            default: s.rdat = {r.rdat[30:0], LINK.d_out[1]};
          endcase
        end
        if (r.st == HS_DUMMY) begin
          s.dum = r.dum - 4'h1;
          last = (r.dum == 4'h1);
        end else begin
          s.bits = r.bits - 6'(w);
          last = (r.bits == 6'(w));
        end
        if (last) begin
          s.bits = {nbc, 3'b000};
          case (r.st)
            HS_OP: begin
              s.st = (r.cmdw[7:0] == sser_pkg::OP_CLR_LOG) ? HS_END : HS_ADDR;
              s.bits = sser_pkg::ADDR_BITS;
            end
            HS_ADDR: begin
              if (!is_wr && r.cmdw[sser_pkg::CMD_LAT_LSB +: 4] != '0) begin
                s.st = HS_DUMMY;
                s.dum = r.cmdw[sser_pkg::CMD_LAT_LSB +: 4];
              end else begin
                s.st = post;
              end
            end
            HS_DUMMY: s.st = post;
            default: s.st = HS_END;
          endcase
        end
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= HOST_RST;
    end else begin
      r <= s;
    end
  end

  assign AWREADY = r.awready;
  assign WREADY = r.wready;
  assign BVALID = r.bvalid;
  assign BRESP = r.bresp;
  assign ARREADY = r.arready;
  assign RVALID = r.rvalid;
  assign RDATA = r.rdata;
  assign RRESP = r.rresp;
  assign LINK.cs_n = r.cs_n;
  assign LINK.sck = r.sck;
  assign LINK.h_out = r.hout;
  assign LINK.h_oe = r.hoe;
endmodule

// ===== logic/sser_pkg.sv
// Purpose: shared constants for the special sector and ECC report link
// Assumes: one clock domain, SPI mode 0 framing on the link
// Notes: host register map and device register-read map live here
package sser_pkg;
  // Command opcodes
  localparam logic [7:0] OP_SEC_WR = 8'h42;
  localparam logic [7:0] OP_SEC_RD = 8'h4B;
  localparam logic [7:0] OP_UNIT_Q = 8'h19;
  localparam logic [7:0] OP_CLR_LOG = 8'h1B;
  localparam logic [7:0] OP_REG_RD = 8'h65;
  // Lane modes: single, dual_lane_mode, quad_lane_mode
  localparam logic [1:0] LANES_SINGLE = 2'h0;
  localparam logic [1:0] LANES_DUAL = 2'h1;
  localparam logic [1:0] LANES_QUAD = 2'h2;
  // Output enables per mode
  localparam logic [3:0] OE_HOST_SINGLE = 4'h1;
  localparam logic [3:0] OE_DEV_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hF;
  // Field sizes
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [5:0] OP_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [1:0] ADDR_LAST = 2'h2;
  localparam logic [2:0] NB_MAX = 3'h4;
  localparam int DBF_BIT = 4;
  localparam logic [23:0] UNIT_MASK = 24'hFFFFF8;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  // Register-read selectors (low address byte)
  localparam logic [7:0] REG_ECC_STATUS = 8'h00;
  localparam logic [7:0] REG_TRAP0 = 8'h04;
  localparam logic [7:0] REG_TRAP1 = 8'h05;
  localparam logic [7:0] REG_TRAP2 = 8'h06;
  localparam logic [7:0] REG_TRAP3 = 8'h07;
  localparam logic [7:0] REG_CNT0 = 8'h08;
  localparam logic [7:0] REG_CNT1 = 8'h09;
  // Host AXI4-Lite map
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_ADDR = 8'h04;
  localparam logic [7:0] HR_WDATA = 8'h08;
  localparam logic [7:0] HR_RDATA = 8'h0C;
  localparam logic [7:0] HR_STAT = 8'h10;
  localparam int CMD_LANE_LSB = 8;
  localparam int CMD_LAT_LSB = 10;
  localparam int CMD_NB_LSB = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  // Bits moved per clock for a lane mode
  function automatic logic [3:0] lane_bits(input logic [1:0] mode);
    case (mode)
      LANES_DUAL: lane_bits = 4'h2;
      LANES_QUAD: lane_bits = 4'h4;
      default: lane_bits = 4'h1;
    endcase
  endfunction
endpackage

// ===== logic/sser_link_if.sv
// Purpose: link between host controller and memory device
// Assumes: each end reads the other end's values directly; the bench only checks the two enable sets
// Notes: no high-impedance values; each side drives value and enable
`timescale 1ns/100ps
interface sser_link_if;
  logic cs_n;
  logic sck;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  modport host (output cs_n, output sck, output h_out, output h_oe,
    input d_out, input d_oe);
  modport dev (input cs_n, input sck, input h_out, input h_oe,
    output d_out, output d_oe);
endinterface

// ===== logic/sser_dev.sv
// Summary of operation
// - Write data uses one, two or four lanes
// - Burst write stores bytes at rising addresses
// - Host ends single write right after LSB
// - Host ends burst at top sector address
// - Data MSB first; write ends at CS rise
// - Three address bytes; low byte selects sector
// - Sector write only with write latch set
// - Write latch clears when sector write ends
// - Sector read auto-increments from any byte
// - Past top address read data undefined
// - Read dummy cycles from latency code
// - ECC always on, double errors reported
// - Single-bit errors corrected, never reported
// - Double error sets flag bit four
// - Trap keeps first double-error unit address; deep sleep zeros it here and it stays zero while the flag is set
// - Counter counts every double error
// - Counter saturates at all ones
// - Flag, trap, counter cleared on resets
// - Deep sleep empties counter to zero
// - Status, counter only via register read
// - Unit query returns unit double-error status
// - No ECC on sector or registers
// - Clear command clears log, no latch
//
// Purpose: device end: special sector access and ECC error log
// Assumes: link pins synchronous to MCLK; sck much slower than MCLK
// Notes: array read engine reports double errors on DBE_EVENT
`timescale 1ns/100ps
module sser_dev #(
  parameter int SECTOR_BYTES = 256
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  sser_link_if.dev LINK,
  input wire logic [1:0] LANE_MODE,
  input wire logic [3:0] LAT_CODE,
  input wire logic WEL_SET,
  input wire logic DEEP_SLEEP,
  input wire logic DBE_EVENT,
  input wire logic [23:0] DBE_ADDR,
  input wire logic UNIT_DBE,
  output logic WEL_FLAG,
  output logic DBL_FLAG,
  output logic [31:0] TRAP_ADDR,
  output logic [15:0] ERR_COUNT,
  output logic [23:0] UNIT_ADDR
);
  if (SECTOR_BYTES != 256) begin : g_chk
    $error("sector depth is fixed by the 8-bit sector address");
  end

  typedef enum logic [2:0] {
    ST_OP, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_SKIP
  } sser_dst_t;

  typedef struct packed {
    sser_dst_t st;
    logic sck_q;
    logic cs_q;
    logic [7:0] sh;
    logic [3:0] nbit;
    logic [7:0] op;
    logic [1:0] abytes;
    logic [23:0] addr;
    logic [23:0] uaddr;
    logic [3:0] dcnt;
    logic [7:0] ob;
    logic [3:0] ocnt;
    logic [3:0] dout;
    logic [3:0] doe;
    logic write_latch_flag;
    logic dbf;
    logic [31:0] trap;
    logic [15:0] cnt;
    logic [255:0][7:0] mem;
  } sser_dev_t;

  localparam sser_dev_t DEV_RST = '{st: ST_OP, cs_q: 1'b1, default: '0};

  sser_dev_t r;
  sser_dev_t s;
  logic rise;
  logic fall;
  logic cs_rise;
  logic byte_done;
  logic clr_log;
  logic wel_clr;
  logic [3:0] w;
  logic [3:0] nb;
  logic [7:0] nsh;
  logic [7:0] src;
  logic [7:0] cur;
  logic [3:0] rem;
  logic [23:0] full_addr;

  // Assemble incoming lane bits into a byte, MSB first
  function automatic logic [7:0] shift_in(input logic [7:0] v,
      input logic [1:0] mode, input logic [3:0] io);
    case (mode)
      sser_pkg::LANES_DUAL: shift_in = {v[5:0], io[1:0]};
      sser_pkg::LANES_QUAD: shift_in = {v[3:0], io};
      default: shift_in = {v[6:0], io[0]};
    endcase
  endfunction

  // Byte source for read phases
  always_comb begin
    src = '0;
    case (r.op)
      sser_pkg::OP_SEC_RD: src = r.mem[r.addr[7:0]];
      sser_pkg::OP_UNIT_Q: begin
        src[sser_pkg::DBF_BIT] = UNIT_DBE;
      end
      sser_pkg::OP_REG_RD: begin
        // Log registers are reachable on this path only
        case (r.addr[7:0])
          sser_pkg::REG_ECC_STATUS: src[sser_pkg::DBF_BIT] = r.dbf;
          sser_pkg::REG_TRAP0: src = r.trap[7:0];
          sser_pkg::REG_TRAP1: src = r.trap[15:8];
          sser_pkg::REG_TRAP2: src = r.trap[23:16];
          sser_pkg::REG_TRAP3: src = r.trap[31:24];
          sser_pkg::REG_CNT0: src = r.cnt[7:0];
          sser_pkg::REG_CNT1: src = r.cnt[15:8];
          default: src = '0;
        endcase
      end
      default: src = '0;
    endcase
  end

  // Next state of link, sector and error log
  always_comb begin
    s = r;
    clr_log = 1'b0;
    wel_clr = 1'b0;
    w = sser_pkg::lane_bits(LANE_MODE);
    rise = LINK.sck & ~r.sck_q;
    fall = ~LINK.sck & r.sck_q;
    cs_rise = LINK.cs_n & ~r.cs_q;
    nsh = shift_in(r.sh, LANE_MODE, LINK.h_out);
    nb = r.nbit + w;
    byte_done = (nb == sser_pkg::BYTE_BITS);
    full_addr = {r.addr[15:0], nsh};
    cur = (r.ocnt == '0) ? src : r.ob;
    rem = ((r.ocnt == '0) ? sser_pkg::BYTE_BITS : r.ocnt) - w;
    s.sck_q = LINK.sck;
    s.cs_q = LINK.cs_n;
    if (LINK.cs_n) begin
      // Frame over: a partial byte is dropped
      s.st = ST_OP;
      s.nbit = '0;
      s.ocnt = '0;
      s.doe = '0;
      s.op = '0;
      s.abytes = '0;
      wel_clr = cs_rise && (r.op == sser_pkg::OP_SEC_WR);
    end else if (rise) begin
      s.sh = nsh;
      s.nbit = byte_done ? '0 : nb;
      case (r.st)
        ST_OP: begin
          if (byte_done) begin
            s.op = nsh;
            s.st = ST_ADDR;
            case (nsh)
              sser_pkg::OP_SEC_WR, sser_pkg::OP_SEC_RD,
              sser_pkg::OP_UNIT_Q, sser_pkg::OP_REG_RD: s.st = ST_ADDR;
              sser_pkg::OP_CLR_LOG: begin
                clr_log = 1'b1;
                s.st = ST_SKIP;
              end
              default: s.st = ST_SKIP;
            endcase
          end
        end
        ST_ADDR: begin
          if (byte_done) begin
            // Upper bytes kept; only the unit query uses them, other commands address with the low byte
            s.addr = full_addr;
            s.abytes = r.abytes + 2'h1;
            if (r.abytes == sser_pkg::ADDR_LAST) begin
              if (r.op == sser_pkg::OP_UNIT_Q) begin
                s.uaddr = full_addr & sser_pkg::UNIT_MASK;
              end
              if (r.op == sser_pkg::OP_SEC_WR) begin
                s.st = ST_WDATA;
              end else if (LAT_CODE == '0) begin
                s.st = ST_RDATA;
              end else begin
                s.st = ST_DUMMY;
                s.dcnt = LAT_CODE;
              end
            end
          end
        end
        ST_DUMMY: begin
          s.dcnt = r.dcnt - 4'h1;
          if (r.dcnt == 4'h1) begin
            s.st = ST_RDATA;
          end
        end
        ST_WDATA: begin
          if (byte_done) begin
            // Sector bytes bypass ECC entirely
            if (r.write_latch_flag) begin
              s.mem[r.addr[7:0]] = nsh;
            end
            s.addr[7:0] = r.addr[7:0] + 8'h01;
          end
        end
        default: s.st = r.st;
      endcase
    end else if (fall && r.st == ST_RDATA) begin
      // Shift out on falling edges so the host samples on rising
      case (LANE_MODE)
        sser_pkg::LANES_DUAL: begin
          s.dout = {2'b00, cur[7:6]};
          s.doe = sser_pkg::OE_DUAL;
        end
        sser_pkg::LANES_QUAD: begin
          s.dout = cur[7:4];
          s.doe = sser_pkg::OE_QUAD;
        end
        default: begin
          s.dout = {2'b00, cur[7], 1'b0};
          s.doe = sser_pkg::OE_DEV_SINGLE;
        end
      endcase
      s.ob = cur << w;
      s.ocnt = rem;
      // Wraps past the top; such bytes are undefined
      if (rem == '0) begin
        s.addr[7:0] = r.addr[7:0] + 8'h01;
      end
    end
    // Write latch: a set in the same cycle as the clear wins
    if (wel_clr) begin
      s.write_latch_flag = 1'b0;
    end
    if (WEL_SET) begin
      s.write_latch_flag = 1'b1;
    end
    // Clears first, so an event in the same cycle survives
    if (clr_log) begin
      s.dbf = 1'b0;
      s.trap = '0;
      s.cnt = '0;
    end
    if (DEEP_SLEEP) begin
      s.cnt = '0;
      s.trap = '0;
    end
    // Only double errors arrive here; single ones are fixed
    if (DBE_EVENT) begin
      if (!s.dbf) begin
        s.trap = {8'h00, DBE_ADDR & sser_pkg::UNIT_MASK};
      end
      s.dbf = 1'b1;
      if (s.cnt != sser_pkg::CNT_MAX) begin
        s.cnt = s.cnt + 16'h0001;
      end
    end
  end

  // State register; power-on and reset events clear the log
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      r <= DEV_RST;
    end else begin
      r <= s;
    end
  end

  assign LINK.d_out = r.dout;
  assign LINK.d_oe = r.doe;
  assign WEL_FLAG = r.write_latch_flag;
  assign DBL_FLAG = r.dbf;
  assign TRAP_ADDR = r.trap;
  assign ERR_COUNT = r.cnt;
  assign UNIT_ADDR = r.uaddr;
endmodule

// ===== testbench/sser_asserts.sv
// Purpose: link and error log checks for the sector and ECC pair
// Assumes: one clock, reset active low, log judged outside frames
// Notes: clear only runs inside a frame, so cs_n high rules it out
`timescale 1ns/100ps
module sser_asserts (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic cs_n,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_oe,
  input wire logic WEL_FLAG,
  input wire logic DEEP_SLEEP,
  input wire logic DBE_EVENT,
  input wire logic [23:0] DBE_ADDR,
  input wire logic DBL_FLAG,
  input wire logic [31:0] TRAP_ADDR,
  input wire logic [15:0] ERR_COUNT
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!ARST_N);
  // Quiet cycle: no frame and no sleep can race a log event
  logic q;
  assign q = cs_n && !DEEP_SLEEP;
  // Lane ownership and latch end
  lanes_apart_a: assert property ((h_oe & d_oe) == 4'h0)
    else $error("both ends drive one lane");
  wel_end_a: assert property ($fell(WEL_FLAG) |-> $past(cs_n) && !$past(cs_n, 2))
    else $error("write latch fell away from chip select rise");
  // Error log updates
  flag_set_a: assert property (DBE_EVENT |=> DBL_FLAG)
    else $error("double flag not set");
  trap_load_a: assert property (DBE_EVENT && !DBL_FLAG && q |=>
    TRAP_ADDR == {8'h00, $past(DBE_ADDR) & sser_pkg::UNIT_MASK})
    else $error("trap did not take first unit address");
  trap_hold_a: assert property (DBL_FLAG && q |=> $stable(TRAP_ADDR))
    else $error("trap overwritten");
  count_step_a: assert property (DBE_EVENT && q && ERR_COUNT != 16'hFFFF |=>
    ERR_COUNT == $past(ERR_COUNT) + 16'h0001)
    else $error("counter did not step by one");
  count_sat_a: assert property (ERR_COUNT == 16'hFFFF && q |=>
    ERR_COUNT == 16'hFFFF)
    else $error("counter left all ones");
  sleep_zero_a: assert property ((DEEP_SLEEP && !DBE_EVENT) ##1 DEEP_SLEEP
    |-> ERR_COUNT == 16'h0000 && TRAP_ADDR == 32'h0)
    else $error("sleep left counter or trap set");
  // Main scenarios
  cover property (DBE_EVENT && DBL_FLAG);
  cover property ($fell(WEL_FLAG));
  cover property (ERR_COUNT == 16'hFFFF && DBE_EVENT);
endmodule

// ===== testbench/test_special_sector_and_ecc_report.sv
// Purpose: bench for host and device ends of the sector and ECC link
// Assumes: host DIV of 3 keeps frames short
// Notes: log events driven at the device
`timescale 1ns/100ps
module test_special_sector_and_ecc_report;
  logic MCLK = 1'b0;
  logic ARST_N = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
  logic [1:0] LANE_MODE = 2'h0;
  logic [3:0] LAT_CODE = 4'h0;
  logic WEL_SET = 0, DEEP_SLEEP = 0, DBE_EVENT = 0, UNIT_DBE = 0;
  logic [23:0] DBE_ADDR = 24'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WEL_FLAG, DBL_FLAG;
  logic [1:0] BRESP, RRESP;
  logic [31:0] RDATA, TRAP_ADDR;
  logic [15:0] ERR_COUNT;
  logic [23:0] UNIT_ADDR;
  int fail_count = 0, num_checks = 0;
  sser_link_if sser_link_if_i ();
  sser_host #(.DIV(3)) sser_host_i (.MCLK(MCLK), .ARST_N(ARST_N),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(4'hF), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .LINK(sser_link_if_i.host));
  sser_dev sser_dev_i (.MCLK(MCLK), .ARST_N(ARST_N),
    .LINK(sser_link_if_i.dev), .LANE_MODE(LANE_MODE), .LAT_CODE(LAT_CODE),
    .WEL_SET(WEL_SET), .DEEP_SLEEP(DEEP_SLEEP), .DBE_EVENT(DBE_EVENT),
    .DBE_ADDR(DBE_ADDR), .UNIT_DBE(UNIT_DBE), .WEL_FLAG(WEL_FLAG),
    .DBL_FLAG(DBL_FLAG), .TRAP_ADDR(TRAP_ADDR), .ERR_COUNT(ERR_COUNT),
    .UNIT_ADDR(UNIT_ADDR));
  sser_asserts sser_asserts_i (.MCLK(MCLK), .ARST_N(ARST_N),
    .cs_n(sser_link_if_i.cs_n), .h_oe(sser_link_if_i.h_oe),
    .d_oe(sser_link_if_i.d_oe), .WEL_FLAG(WEL_FLAG),
    .DEEP_SLEEP(DEEP_SLEEP), .DBE_EVENT(DBE_EVENT), .DBE_ADDR(DBE_ADDR),
    .DBL_FLAG(DBL_FLAG), .TRAP_ADDR(TRAP_ADDR), .ERR_COUNT(ERR_COUNT));
  // 125 MHz clock
  initial begin
    forever #4 MCLK = ~MCLK;
  end
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e,
    input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  task automatic stall(input string what);
    fail_count++;
    $display("unexpected %s: no answer", what);
    wrap_up();
  endtask
  // Both write channels offered at once
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
    input logic [1:0] er);
    int n;
    logic ta, tw, tb;
    tb = 1'b0;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (n = 0; n < 50 && !tb; n++) begin
      @(negedge MCLK);
      {ta, tw, tb} = {AWREADY, WREADY, BVALID};
      @(posedge MCLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
    end
    if (!tb) stall("write response");
    BREADY <= 1'b0;
    chk("write response", {30'h0, er}, {30'h0, BRESP});
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    logic ta, tr;
    tr = 1'b0;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (n = 0; n < 50 && !tr; n++) begin
      @(negedge MCLK);
      {ta, tr} = {ARREADY, RVALID};
      @(posedge MCLK);
      if (ta) ARVALID <= 1'b0;
    end
    if (!tr) stall("read data");
    d = RDATA;
    r = RRESP;
    RREADY <= 1'b0;
  endtask
  function automatic logic [31:0] cw(input logic [7:0] op,
    input logic [1:0] m, input logic [3:0] l, input logic [2:0] nb);
    cw = {13'h0, nb, 2'h0, l, m, op};
  endfunction
  // One link frame; device follows the command
  task automatic frame(input logic [31:0] c, input logic [23:0] a,
    input logic [31:0] wd);
    logic [31:0] s;
    logic [1:0] r;
    int n;
    @(posedge MCLK);
    LANE_MODE <= c[9:8];
    LAT_CODE <= c[13:10];
    axi_wr(sser_pkg::HR_ADDR, {8'h00, a}, sser_pkg::AXI_OKAY);
    axi_wr(sser_pkg::HR_WDATA, wd, sser_pkg::AXI_OKAY);
    axi_wr(sser_pkg::HR_CMD, c, sser_pkg::AXI_OKAY);
    s = 32'h0;
    for (n = 0; n < 400 && s[1] !== 1'b1; n++) axi_rd(sser_pkg::HR_STAT, s, r);
    if (s[1] !== 1'b1) stall("frame end");
  endtask
  // Read frame, compare the bytes shifted in
  task automatic rd_chk(input logic [31:0] c, input logic [23:0] a,
    input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    frame(c, a, 32'h0);
    axi_rd(sser_pkg::HR_RDATA, d, r);
    chk("read bytes", e, d & (32'hFFFFFFFF >> (8 * (4 - c[18:16]))));
  endtask
  task automatic sector(input logic [1:0] m, input logic [23:0] a,
    input logic [2:0] nb, input logic [31:0] wd, input logic write_latch_flag,
    input logic [31:0] e);
    @(posedge MCLK);
    WEL_SET <= write_latch_flag;
    @(posedge MCLK);
    WEL_SET <= 1'b0;
    @(posedge MCLK);
    chk("latch before write", {31'h0, write_latch_flag}, {31'h0, WEL_FLAG});
    frame(cw(sser_pkg::OP_SEC_WR, m, 4'h0, nb), a, wd);
    chk("latch after write", 32'h0, {31'h0, WEL_FLAG});
    rd_chk(cw(sser_pkg::OP_SEC_RD, m, {m, 2'h1}, nb), a, e);
  endtask
  task automatic dbe(input logic [23:0] a);
    @(posedge MCLK);
    DBE_EVENT <= 1'b1;
    DBE_ADDR <= a;
    @(posedge MCLK);
    DBE_EVENT <= 1'b0;
    @(posedge MCLK);
  endtask
  task automatic log_chk(input logic f, input logic [31:0] t,
    input logic [15:0] c);
    chk("double flag", {31'h0, f}, {31'h0, DBL_FLAG});
    chk("trap", t, TRAP_ADDR);
    chk("count", {16'h0, c}, {16'h0, ERR_COUNT});
  endtask
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    log_chk(1'b0, 32'h0, 16'h0); // log clear
    axi_wr(8'h20, 32'h0, sser_pkg::AXI_SLVERR);
    axi_rd(8'h20, d, r);
    chk("unmapped read", {2'h2, 30'h0}, {r, d[29:0]});
    sector(2'h0, 24'h10, 3'h1, 32'hA5000000, 1'b1, 32'hA5);
    sector(2'h0, 24'h10, 3'h1, 32'h5A000000, 1'b0, 32'hA5);
    for (int m = 0; m < 3; m++) begin
      sector(m[1:0], 24'hFC, 3'h4, 32'h1E2D3C4B + m, 1'b1, 32'h1E2D3C4B + m);
    end
    log_chk(1'b0, 32'h0, 16'h0); // log untouched by sector traffic
    dbe(24'h012345);
    log_chk(1'b1, 32'h00012340, 16'h1);
    dbe(24'h0ABCDF);
    log_chk(1'b1, 32'h00012340, 16'h2);
    rd_chk(cw(sser_pkg::OP_REG_RD, 2'h0, 4'h2, 3'h1), 24'h0, 32'h10);
    rd_chk(cw(sser_pkg::OP_REG_RD, 2'h1, 4'h0, 3'h4), 24'h4, 32'h40230100);
    rd_chk(cw(sser_pkg::OP_REG_RD, 2'h2, 4'h1, 3'h2), 24'h8, 32'h0200);
    UNIT_DBE <= 1'b1;
    rd_chk(cw(sser_pkg::OP_UNIT_Q, 2'h1, 4'h3, 3'h1), 24'h127, 32'h10);
    chk("unit address", 32'h120, {8'h00, UNIT_ADDR});
    UNIT_DBE <= 1'b0;
    rd_chk(cw(sser_pkg::OP_UNIT_Q, 2'h2, 4'h0, 3'h1), 24'h128, 32'h0);
    frame(cw(sser_pkg::OP_CLR_LOG, 2'h0, 4'h0, 3'h0), 24'h0, 32'h0);
    log_chk(1'b0, 32'h0, 16'h0); // clear without latch
    dbe(24'h00000B);
    DEEP_SLEEP <= 1'b1;
    repeat (3) @(posedge MCLK);
    DEEP_SLEEP <= 1'b0;
    log_chk(1'b1, 32'h0, 16'h0);
    frame(cw(sser_pkg::OP_CLR_LOG, 2'h2, 4'h0, 3'h0), 24'h0, 32'h0);
    // One extra event past all ones
    DBE_EVENT <= 1'b1;
    DBE_ADDR <= 24'h7FFFFF;
    repeat (65536) @(posedge MCLK);
    DBE_EVENT <= 1'b0;
    repeat (2) @(posedge MCLK);
    log_chk(1'b1, 32'h007FFFF8, 16'hFFFF);
    ARST_N <= 1'b0;
    repeat (2) @(posedge MCLK);
    ARST_N <= 1'b1;
    @(posedge MCLK);
    log_chk(1'b0, 32'h0, 16'h0); // second reset
    wrap_up();
  end
endmodule
